// [rtl/cmaf_pkg.sv]
// cmaf_pkg: register map, field positions, reset values and constants
// for the codec mix, attenuate and format path. No clock assumptions.
package cmaf_pkg;
    // register indices on the 4-bit register port
    localparam logic [3:0]  A_CD_GAIN    = 4'h0;
    localparam logic [3:0]  A_MUSIC_GAIN = 4'h1;
    localparam logic [3:0]  A_PHONE_GAIN = 4'h2;
    localparam logic [3:0]  A_OUT_ATT    = 4'h3;
    localparam logic [3:0]  A_MIX_ATT    = 4'h4;
    localparam logic [3:0]  A_CTRL       = 4'h5;
    localparam logic [3:0]  A_STATUS     = 4'h6;
    localparam logic [3:0]  A_APPLIED    = 4'h7;
    // per-channel field layout: code in low bits, mute at bit 7 of the byte
    localparam int          CH_STRIDE    = 8;
    localparam int          MUTE_POS     = 7;
    localparam int          MUTE_L       = 7;
    // control register fields
    localparam int          CTL_ZC       = 0;
    localparam int          CTL_BOOST_L  = 1;
    localparam int          CTL_BOOST_R  = 2;
    localparam int          CTL_LMUTE_L  = 3;
    localparam int          CTL_LMUTE_R  = 4;
    localparam int          CTL_HPMONO   = 5;
    localparam int          CTL_MIXPD    = 6;
    localparam int          CTL_PLAY     = 7;
    localparam int          CTL_FMT_LEFT_INPUT_CONVERTER = 8;
    localparam int          CTL_FMT_PRIMARY_OUTPUT_CONVERTER_PAIR = 12;
    // reset values: 0 dB codes, muted; control all zero, so line and headphone mutes are off
    localparam logic [15:0] RST_GAIN     = 16'h8888;
    localparam logic [15:0] RST_OUT_ATT  = 16'h8888;
    localparam logic [15:0] RST_MIX_ATT  = 16'h8080;
    localparam logic [15:0] RST_CTRL     = 16'h0000;
    // zero-cross timeout, in sample periods, minus one
    localparam logic [8:0]  ZC_TMO_LAST  = 9'h17F;
    // 1.5 dB step mantissas, Q15
    localparam logic [16:0] MANT_0       = 17'h08000;
    localparam logic [16:0] MANT_1       = 17'h06BB3;
    localparam logic [16:0] MANT_2       = 17'h05A9E;
    localparam logic [16:0] MANT_3       = 17'h04C3F;
    // saturation limits
    localparam logic signed [17:0] SAT_HI = 18'sh07FFF;
    localparam logic signed [17:0] SAT_LO = 18'sh38000;
    localparam logic [15:0] FS_POS       = 16'h7FFF;
    localparam logic [15:0] FS_NEG       = 16'h8000;
    // companding constants
    localparam logic [15:0] MU_BIAS      = 16'h0084;
    localparam logic [15:0] MU_CLIP      = 16'h7F7B;
    localparam logic [7:0]  ALAW_XOR     = 8'h55;
    localparam logic [7:0]  ALAW_POS     = 8'hD5;
    localparam logic [15:0] ALAW_ADD0    = 16'h0008;
    localparam logic [15:0] ALAW_ADD     = 16'h0108;

    typedef enum logic [1:0] {
        FMT_PCM16 = 2'h0,
        FMT_U8    = 2'h1,
        FMT_MULAW = 2'h2,
        FMT_ALAW  = 2'h3
    } cmaf_fmt_e;
endpackage

// [rtl/cmaf_expand.sv]
// cmaf_expand: one incoming sample word to 16-bit linear.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module cmaf_expand
    import cmaf_pkg::*;
(
    // serial word, msb in bit 15, and its format
    input  wire logic [15:0] i_word,
    input  wire cmaf_fmt_e   i_fmt,
    // linear result
    output logic      [15:0] o_lin
);
    logic [7:0]  b;
    logic [15:0] t;

    // 8-bit formats use the upper byte only
    always_comb
    begin
        b     = i_word[15:8];
        t     = 16'h0000;
        o_lin = i_word;
        unique case (i_fmt)
            FMT_PCM16: o_lin = i_word;
            FMT_U8:    o_lin = {~b[7], b[6:0], 8'h00};
            FMT_MULAW:
            begin
                b     = ~b;
                t     = ({12'h000, b[3:0]} << 3) + MU_BIAS;
                t     = t << b[6:4];
                o_lin = b[7] ? (MU_BIAS - t) : (t - MU_BIAS);
            end
            FMT_ALAW:
            begin
                b = b ^ ALAW_XOR;
                t = {8'h00, b[3:0], 4'h0};
                if (b[6:4] == 3'h0)
                    t = t + ALAW_ADD0;
                else
                    t = (t + ALAW_ADD) << (b[6:4] - 3'h1);
                o_lin = b[7] ? t : (16'h0000 - t);
            end
        endcase
    end
endmodule

// [rtl/cmaf_compress.sv]
// cmaf_compress: 16-bit linear sample to an outgoing serial word.
// Purely combinational; 8-bit results sit in the upper byte.
`timescale 1ns/1ps
module cmaf_compress
    import cmaf_pkg::*;
(
    // linear input and target format
    input  wire logic [15:0] i_lin,
    input  wire cmaf_fmt_e   i_fmt,
    // serial word, msb in bit 15
    output logic      [15:0] o_word
);
    logic [15:0] m;
    logic [2:0]  e;
    logic [7:0]  k;
    logic [7:0]  y;

    // mu-law works on biased magnitude, a-law on the value shifted by 3
    always_comb
    begin
        m = 16'h0000;
        e = 3'h0;
        k = ALAW_POS;
        y = 8'h00;
        unique case (i_fmt)
            FMT_PCM16: y = 8'h00;
            FMT_U8:    y = {~i_lin[15], i_lin[14:8]};
            FMT_MULAW:
            begin
                m = i_lin[15] ? (16'h0000 - i_lin) : i_lin;
                if (m > MU_CLIP)
                    m = MU_CLIP;
                m = m + MU_BIAS;
                for (int i = 0; i < 8; i++)
                    if (m[i + 7])
                        e = 3'(i);
                m = m >> ({1'b0, e} + 4'h3); // 4-bit sum: a 3-bit one wraps for the top segments
                y = ~{i_lin[15], e, m[3:0]};
            end
            FMT_ALAW:
            begin
                m = {{3{i_lin[15]}}, i_lin[15:3]};
                if (i_lin[15])
                begin
                    k = ALAW_XOR;
                    m = ~m;
                end
                for (int i = 1; i < 8; i++)
                    if (m[i + 4])
                        e = 3'(i);
                m = (e < 3'h2) ? (m >> 1) : (m >> e);
                y = {1'b0, e, m[3:0]} ^ k;
            end
        endcase
        // msb leads on the serial line, low byte zero for 8-bit data
        o_word = (i_fmt == FMT_PCM16) ? i_lin : {y, 8'h00};
    end
endmodule

// [rtl/cmaf_top.sv]
// cmaf_top: digital mix, output attenuation with zero-cross update,
// format conversion and analog mix controls of a stereo codec.
// Assumes sample strobes from on-chip generators on i_clk_sys and a
// register master that issues at most one strobe per cycle.
//
// What this block does
// - each aux mix channel has own gain +12 to -34.5 dB, 1.5 dB, or mute
// - analog mix stays enabled even when nothing is played back
// - feed-through pin plus mixer power-down routes mono input to mono out
// - input converter overrange sets software-readable status bits
// - selectable +20 dB boost on each speech pickup channel
// - output attenuation per channel +12 to -82.5 dB in 1.5 dB, plus mute
// - new attenuation applies at once or at sign change, per channel
// - pending change is forced after 384 sample periods without sign change
// - mix samples are attenuated; serial input samples stay untouched
// - mix attenuation per side, 64 steps of -1.5 dB, plus full mute
// - all processing is 16-bit linear; conversion only at the boundaries
// - mix is added ahead of the output attenuators
// - mix sum saturates at full scale, never wraps
// - a late playback sample counts as zero in the sum
// - line outputs mute separately; headphone and mono share one mute
// - each conversion resource selects one of four sample formats
// - sample words go msb first both ways
// - 8-bit samples use the upper byte; low byte ignored in, zero out
// - companded bytes expand to linear by the selected law
// - companded input converter formats are compressed before sending
`timescale 1ns/1ps
module cmaf_top
    import cmaf_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    input  wire logic        i_ce,
    // register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [15:0] i_wr_data,
    input  wire logic        i_wr_stb,
    input  wire logic        i_rd_stb,
    output logic      [15:0] o_rd_data,
    // playback words from the serial port
    input  wire logic        i_play_stb,
    input  wire logic        i_play_vld,
    input  wire logic [15:0] i_primary_word_l,
    input  wire logic [15:0] i_primary_word_r,
    input  wire logic [15:0] i_secondary_word_l,
    input  wire logic [15:0] i_secondary_word_r,
    // input converter samples and asynchronous pins
    input  wire logic        i_adc_stb,
    input  wire logic [15:0] i_adc_l,
    input  wire logic [15:0] i_adc_r,
    input  wire logic        i_ovr_l,
    input  wire logic        i_ovr_r,
    input  wire logic        i_mono_feedthrough_powerdown_pin,
    // to the output converters, linear
    output logic      [15:0] o_primary_out_l,
    output logic      [15:0] o_primary_out_r,
    output logic      [15:0] o_secondary_out_l,
    output logic      [15:0] o_secondary_out_r,
    // to the serial port
    output logic      [15:0] o_adc_word_l,
    output logic      [15:0] o_adc_word_r,
    // analog controls
    output logic      [15:0] o_cd_line_gain,
    output logic      [15:0] o_music_line_gain,
    output logic      [15:0] o_phone_line_gain,
    output logic      [1:0]  o_mic_boost,
    output logic      [1:0]  o_mixer_line_mute,
    output logic             o_hp_mono_mute,
    output logic             o_mixer_en,
    output logic             o_mono_feedthru
);
    logic [15:0] aux_q [3];
    logic [15:0] aux_d [3];
    logic [15:0] oatt_q, oatt_d, matt_q, matt_d, ctl_q, ctl_d, rd_q, rd_d;
    logic [2:0]  sts_q, sts_d;
    logic [2:0]  sy1_q, sy2_q;
    logic [15:0] hold_q [2];
    logic [15:0] hold_d [2];
    logic [6:0]  app_q  [2];
    logic [6:0]  app_d  [2];
    logic [8:0]  tmo_q  [2];
    logic [8:0]  tmo_d  [2];
    logic        sgn_q  [2];
    logic        sgn_d  [2];
    logic [15:0] out_q  [2];
    logic [15:0] out_d  [2];
    logic [15:0] sec_q  [2];
    logic [15:0] sec_d  [2];
    logic [15:0] adw_q  [2];
    logic [15:0] adw_d  [2];
    logic [15:0] word   [4];
    logic [15:0] lin    [4];
    logic [15:0] adc    [2];
    logic [15:0] cmp    [2];
    logic [6:0]  want   [2];
    logic [15:0] mixv   [2];
    logic [15:0] pb     [2];
    logic [15:0] sum    [2];
    logic        und;

    // -1.5 dB per code step: mantissa for code mod 4, shift per 6 dB; sh is unity (15, or 13 for +12 dB)
    function automatic logic [17:0] f_att(input logic [15:0] s, input logic [5:0] code, input logic [4:0] sh);
        logic signed [33:0] p;
        logic        [16:0] m;
        unique case (code[1:0])
            2'h0: m = MANT_0;
            2'h1: m = MANT_1;
            2'h2: m = MANT_2;
            2'h3: m = MANT_3;
        endcase
        p = $signed(s) * $signed(m);
        p = p >>> (sh + {1'b0, code[5:2]});
        return p[17:0];
    endfunction

    // clip to 16-bit full scale instead of wrapping
    function automatic logic [15:0] f_sat(input logic signed [17:0] v);
        if (v > SAT_HI)
            return FS_POS;
        if (v < SAT_LO)
            return FS_NEG;
        return v[15:0];
    endfunction

    // boundary converters; everything between them is 16-bit linear
    assign word[0] = i_primary_word_l;
    assign word[1] = i_primary_word_r;
    assign word[2] = i_secondary_word_l;
    assign word[3] = i_secondary_word_r;
    assign adc[0]  = i_adc_l;
    assign adc[1]  = i_adc_r;
    for (genvar k = 0; k < 4; k++)
    begin : g_exp
        cmaf_expand u_exp (
            .i_word (word[k]),
            .i_fmt  (cmaf_fmt_e'(ctl_q[CTL_FMT_PRIMARY_OUTPUT_CONVERTER_PAIR + 2 * (k / 2) +: 2])),
            .o_lin  (lin[k])
        );
    end
    for (genvar k = 0; k < 2; k++)
    begin : g_cmp
        cmaf_compress u_cmp (
            .i_lin  (adc[k]),
            .i_fmt  (cmaf_fmt_e'(ctl_q[CTL_FMT_LEFT_INPUT_CONVERTER + 2 * k +: 2])),
            .o_word (cmp[k])
        );
    end

    // register file, sticky status and read data
    always_comb
    begin
        aux_d  = aux_q;
        oatt_d = oatt_q;
        matt_d = matt_q;
        ctl_d  = ctl_q;
        rd_d   = 16'h0000;
        sts_d  = sts_q;
        if (i_wr_stb)
        begin
            unique case (i_addr)
                A_CD_GAIN, A_MUSIC_GAIN, A_PHONE_GAIN: aux_d[i_addr[1:0]] = i_wr_data;
                A_OUT_ATT: oatt_d = i_wr_data;
                A_MIX_ATT: matt_d = i_wr_data;
                A_CTRL:    ctl_d  = i_wr_data;
                default:   ctl_d  = ctl_q; // unmapped or read-only: ignored
            endcase
        end
        if (i_rd_stb)
        begin
            unique case (i_addr)
                A_CD_GAIN, A_MUSIC_GAIN, A_PHONE_GAIN: rd_d = aux_q[i_addr[1:0]];
                A_OUT_ATT: rd_d = oatt_q;
                A_MIX_ATT: rd_d = matt_q;
                A_CTRL:    rd_d = ctl_q;
                A_STATUS:  rd_d = {11'h000, want[1] != app_q[1], want[0] != app_q[0], sts_q};
                A_APPLIED: rd_d = {app_q[1][6], 1'b0, app_q[1][5:0], app_q[0][6], 1'b0, app_q[0][5:0]};
                default:   rd_d = 16'h0000;
            endcase
            if (i_addr == A_STATUS)
                sts_d = 3'h0; // read clears
        end
        // a new event in the clearing cycle is kept
        sts_d = sts_d | {und, sy2_q[1:0]};
    end

    // output attenuation with zero-cross update and the digital mix
    always_comb
    begin
        hold_d = hold_q;
        app_d  = app_q;
        tmo_d  = tmo_q;
        sgn_d  = sgn_q;
        out_d  = out_q;
        sec_d  = sec_q;
        adw_d  = adw_q;
        und    = ctl_q[CTL_PLAY] && i_play_stb && !i_play_vld;
        for (int c = 0; c < 2; c++)
        begin
            want[c] = {oatt_q[c * CH_STRIDE + MUTE_POS], oatt_q[c * CH_STRIDE +: 6]};
            // mix copy is attenuated; the serial copy is not
            mixv[c] = matt_q[c * CH_STRIDE + MUTE_POS] ? 16'h0000
                    : f_sat(f_att(adc[c], matt_q[c * CH_STRIDE +: 6], 5'h0F));
            if (i_adc_stb)
            begin
                hold_d[c] = mixv[c];
                adw_d[c]  = cmp[c];
            end
            // late or absent playback sample counts as midscale zero
            pb[c]  = (ctl_q[CTL_PLAY] && i_play_vld) ? lin[c] : 16'h0000;
            sum[c] = f_sat({{2{pb[c][15]}}, pb[c]} + {{2{hold_q[c][15]}}, hold_q[c]});
            if (want[c] == app_q[c])
                tmo_d[c] = 9'h000;
            else if (!ctl_q[CTL_ZC])
                app_d[c] = want[c];
            else if (i_play_stb)
            begin
                if ((sum[c][15] != sgn_q[c]) || (tmo_q[c] == ZC_TMO_LAST))
                begin
                    app_d[c] = want[c];
                    tmo_d[c] = 9'h000;
                end
                else
                    tmo_d[c] = tmo_q[c] + 9'h001;
            end
            if (i_play_stb)
            begin
                sgn_d[c] = sum[c][15];
                // code 0 is +12 dB; scaling in one step keeps the low bits, so 0 dB is exact
                out_d[c] = app_d[c][6] ? 16'h0000
                         : f_sat(f_att(sum[c], app_d[c][5:0], 5'h0D));
                sec_d[c] = lin[c + 2];
            end
        end
    end

    // registers; everything freezes while i_ce is low
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
        begin
            aux_q  <= '{RST_GAIN, RST_GAIN, RST_GAIN};
            oatt_q <= RST_OUT_ATT;
            matt_q <= RST_MIX_ATT;
            ctl_q  <= RST_CTRL;
            rd_q   <= 16'h0000;
            sts_q  <= 3'h0;
            sy1_q  <= 3'h0;
            sy2_q  <= 3'h0;
            hold_q <= '{16'h0000, 16'h0000};
            app_q  <= '{7'h48, 7'h48};
            tmo_q  <= '{9'h000, 9'h000};
            sgn_q  <= '{1'b0, 1'b0};
            out_q  <= '{16'h0000, 16'h0000};
            sec_q  <= '{16'h0000, 16'h0000};
            adw_q  <= '{16'h0000, 16'h0000};
        end
        else if (i_ce)
        begin
            aux_q  <= aux_d;
            oatt_q <= oatt_d;
            matt_q <= matt_d;
            ctl_q  <= ctl_d;
            rd_q   <= rd_d;
            sts_q  <= sts_d;
            sy1_q  <= {i_mono_feedthrough_powerdown_pin, i_ovr_r, i_ovr_l};
            sy2_q  <= sy1_q;
            hold_q <= hold_d;
            app_q  <= app_d;
            tmo_q  <= tmo_d;
            sgn_q  <= sgn_d;
            out_q  <= out_d;
            sec_q  <= sec_d;
            adw_q  <= adw_d;
        end
    end

    // outputs; mixer enable ignores playback state on purpose
    assign o_rd_data         = rd_q;
    assign o_primary_out_l   = out_q[0];
    assign o_primary_out_r   = out_q[1];
    assign o_secondary_out_l = sec_q[0];
    assign o_secondary_out_r = sec_q[1];
    assign o_adc_word_l      = adw_q[0];
    assign o_adc_word_r      = adw_q[1];
    assign o_cd_line_gain    = aux_q[0];
    assign o_music_line_gain = aux_q[1];
    assign o_phone_line_gain = aux_q[2];
    assign o_mic_boost       = ctl_q[CTL_BOOST_R:CTL_BOOST_L];
    assign o_mixer_line_mute = ctl_q[CTL_LMUTE_R:CTL_LMUTE_L];
    assign o_hp_mono_mute    = ctl_q[CTL_HPMONO];
    assign o_mixer_en        = !ctl_q[CTL_MIXPD];
    assign o_mono_feedthru   = sy2_q[2] && ctl_q[CTL_MIXPD];

    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rstn);

    a_aux_gain_write: assert property (
        (i_ce && i_wr_stb && i_addr == A_CD_GAIN) |=> o_cd_line_gain == $past(i_wr_data))
        else $error("cd gain not taken");
    a_mixer_alive: assert property (
        (i_ce && i_wr_stb && i_addr == A_CTRL && !i_wr_data[CTL_MIXPD]) |=> o_mixer_en)
        else $error("mixer off without power-down");
    a_feedthru_route: assert property (
        o_mono_feedthru |-> !o_mixer_en && $past(i_mono_feedthrough_powerdown_pin, 2))
        else $error("feed-through without cause");
    a_ovr_sticky: assert property (
        (i_ce && sy2_q[0]) |=> sts_q[0] [*2])
        else $error("overrange flag lost");
    a_boost_write: assert property (
        (i_ce && i_wr_stb && i_addr == A_CTRL) |=> o_mic_boost == $past(i_wr_data[2:1]))
        else $error("boost not taken");
    a_out_mute: assert property (
        (i_ce && i_play_stb && app_d[0][6]) |=> o_primary_out_l == 16'h0000)
        else $error("muted output not zero");
    a_zc_now: assert property (
        (i_ce && !ctl_q[CTL_ZC] && want[0] != app_q[0]) |=> app_q[0] == $past(want[0]))
        else $error("immediate update late");
    a_zc_bound: assert property (
        tmo_q[0] <= ZC_TMO_LAST)
        else $error("zero-cross timeout overrun");
    a_mix_mute: assert property (
        (i_ce && i_adc_stb && matt_q[MUTE_L]) |=> hold_q[0] == 16'h0000)
        else $error("muted mix leaks");
    a_no_wrap: assert property (
        (!pb[0][15] && !hold_q[0][15]) |-> !sum[0][15])
        else $error("mix sum wrapped");
    a_underrun_zero: assert property (
        (i_ce && und && !app_d[0][6] && app_d[0][5:0] == 6'h08) |=> o_primary_out_l == $past(hold_q[0]))
        else $error("underrun not zero");
    a_low_byte: assert property (
        (i_ce && i_adc_stb && ctl_q[9:8] != FMT_PCM16) |=> o_adc_word_l[7:0] == 8'h00)
        else $error("low byte not zero");

    c_zc_timeout: cover property (i_ce && i_play_stb && tmo_q[0] == ZC_TMO_LAST && want[0] != app_q[0]);
    c_underrun: cover property (i_ce && und);
    c_saturate: cover property (i_ce && i_play_stb && sum[0] == FS_POS);
endmodule

// [sim/cmaf_dsp_model.sv]
// cmaf_dsp_model: far-side DSP that hands playback words to the block.
// assumes the bench sets the words and says when a word comes late.
`timescale 1ns/1ps
module cmaf_dsp_model
(
    // words to send and lateness control
    input  wire logic [15:0] i_pl,
    input  wire logic [15:0] i_pr,
    input  wire logic [15:0] i_sl,
    input  wire logic        i_late,
    // towards the block
    output logic             o_vld,
    output logic      [15:0] o_pl,
    output logic      [15:0] o_pr,
    output logic      [15:0] o_sl
);
    // words are parallel with the msb in bit 15
    // a late word carries junk, so a block that uses it anyway is caught
    always_comb
    begin
        o_vld = !i_late;
        o_pl  = i_late ? ~i_pl : i_pl;
        o_pr  = i_late ? ~i_pr : i_pr;
        o_sl  = i_late ? ~i_sl : i_sl;
    end
endmodule

// [sim/tb_cmaf_top.sv]
// tb_cmaf_top: register, format, mix and zero-cross tests of cmaf_top.
// assumes the bench stands in for the on-chip sample strobe generators.
`timescale 1ns/1ps
module tb_cmaf_top
    import cmaf_pkg::*;
;
    localparam logic [15:0] RV [6] = '{RST_GAIN, RST_GAIN, RST_GAIN, RST_OUT_ATT, RST_MIX_ATT, RST_CTRL};
    localparam logic [15:0] AL [4] = '{16'h7FFF, 16'hFF00, 16'h8000, 16'hAA00};
    localparam logic [15:0] AR [4] = '{16'h0000, 16'h8000, 16'hFF00, 16'hD500};
    localparam logic [15:0] SW [4] = '{16'h1234, 16'hFF5A, 16'h805A, 16'hAA5A};
    localparam logic [15:0] SX [4] = '{16'h1234, 16'h7F00, 16'h7D7C, 16'h7E00};
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pstb = 1'b0, astb = 1'b0, ce = 1'b1;
    logic        late = 1'b0, ovl = 1'b0, pin = 1'b0, vld, hpm, mixen, feed;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdat = 16'h0000, adl = 16'h0000, adr = 16'h0000, pl = 16'h0000, pr = 16'h0000;
    logic [15:0] sl = 16'h0000, rdat, pol, por, sol, sor, awl, awr, cdg, mug, phg, wpl, wpr, wsl;
    logic [1:0]  boost, lmute;
    int          failures = 0;
    int          tests_run = 0;

    cmaf_dsp_model i_cmaf_dsp_model
    (
        .i_pl(pl), .i_pr(pr), .i_sl(sl), .i_late(late),
        .o_vld(vld), .o_pl(wpl), .o_pr(wpr), .o_sl(wsl)
    );
    cmaf_top i_cmaf_top
    (
        .i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce),
        .i_addr(addr), .i_wr_data(wdat), .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(rdat),
        .i_play_stb(pstb), .i_play_vld(vld), .i_primary_word_l(wpl), .i_primary_word_r(wpr),
        .i_secondary_word_l(wsl), .i_secondary_word_r(wsl),
        .i_adc_stb(astb), .i_adc_l(adl), .i_adc_r(adr), .i_ovr_l(ovl), .i_ovr_r(ovl),
        .i_mono_feedthrough_powerdown_pin(pin),
        .o_primary_out_l(pol), .o_primary_out_r(por), .o_secondary_out_l(sol), .o_secondary_out_r(sor),
        .o_adc_word_l(awl), .o_adc_word_r(awr),
        .o_cd_line_gain(cdg), .o_music_line_gain(mug), .o_phone_line_gain(phg),
        .o_mic_boost(boost), .o_mixer_line_mute(lmute), .o_hp_mono_mute(hpm),
        .o_mixer_en(mixen), .o_mono_feedthru(feed)
    );

    // 200 MHz system clock
    initial
    begin
        forever #2.5 clk = ~clk;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr   <= 1'b1;
        @(posedge clk);
        wr   <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe, so look there
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        cmp(rdat, e);
    endtask

    // input sample one cycle ahead of the playback strobe, both at one rate
    task automatic smp(input logic [15:0] l, r, p, q, s);
        @(posedge clk);
        adl  <= l;
        adr  <= r;
        astb <= 1'b1;
        @(posedge clk);
        astb <= 1'b0;
        pl   <= p;
        pr   <= q;
        sl   <= s;
        pstb <= 1'b1;
        @(posedge clk);
        pstb <= 1'b0;
        #1;
    endtask

    task automatic plays(input int n);
        repeat (n)
        begin
            @(posedge clk);
            pstb <= 1'b1;
            @(posedge clk);
            pstb <= 1'b0;
        end
        #1;
    endtask

    task automatic wrap_up;
        if (failures == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // a hung run counts as a mismatch
    initial
    begin
        #100000;
        failures++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rdc(i[3:0], RV[i]);
        cmp({15'h0000, mixen}, 16'h0001);
        wrr(4'h7, 16'h0000);
        rdc(4'h7, RST_OUT_ATT);
        rdc(4'h8, 16'h0000);
        wrr(4'h0, 16'h1F80);
        wrr(4'h1, 16'h8000);
        wrr(4'h2, 16'h0A05);
        cmp(cdg, 16'h1F80);
        cmp(mug, 16'h8000);
        cmp(phg, 16'h0A05);
        // a write while the clock enable is low is lost
        @(posedge clk);
        ce <= 1'b0;
        wrr(4'h0, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        cmp(cdg, 16'h1F80);
        wrr(4'h5, 16'h003E);
        cmp({10'h000, boost, lmute, hpm, mixen}, 16'h003F);
        @(posedge clk);
        pin <= 1'b1;
        ovl <= 1'b1;
        wrr(4'h5, 16'h0040);
        repeat (4) @(posedge clk);
        #1;
        cmp({14'h0000, mixen, feed}, 16'h0001);
        rdc(4'h6, 16'h0003);
        @(posedge clk);
        pin <= 1'b0;
        ovl <= 1'b0;
        // every format on both input converters and the secondary pair
        for (int f = 0; f < 4; f++)
        begin
            wrr(4'h5, {f[1:0], 2'b00, f[1:0], f[1:0], 8'h00});
            smp(16'h7FFF, 16'h0000, 16'h0000, 16'h0000, SW[f]);
            cmp(awl, AL[f]);
            cmp(awr, AR[f]);
            cmp(sol, SX[f]);
            cmp(sor, SX[f]);
        end
        // mix ahead of the 0 dB output attenuator, with clipping
        wrr(4'h3, 16'h0808);
        wrr(4'h4, 16'h0000);
        wrr(4'h5, 16'h0080);
        smp(16'h4000, 16'hC000, 16'h4000, 16'hC000, 16'h0000);
        cmp(pol, FS_POS);
        cmp(por, FS_NEG);
        cmp(awl, 16'h4000);
        smp(16'h1000, 16'hF000, 16'h2000, 16'h0000, 16'h0000);
        cmp(pol, 16'h3000);
        cmp(por, 16'hF000);
        @(posedge clk);
        late <= 1'b1;
        smp(16'h1000, 16'h1000, 16'h2000, 16'h2000, 16'h0000);
        cmp(pol, 16'h1000);
        @(posedge clk);
        late <= 1'b0;
        rdc(4'h6, 16'h0007);
        rdc(4'h6, 16'h0000);
        wrr(4'h4, 16'h8080);
        smp(16'h4000, 16'h4000, 16'h1000, 16'h1000, 16'h0000);
        cmp(pol, 16'h1000);
        wrr(4'h4, 16'h0404);
        smp(16'h2000, 16'h2000, 16'h0000, 16'h0000, 16'h0000);
        cmp(pol, 16'h1000);
        // output attenuator +12 dB end, -6 dB and mute
        wrr(4'h3, 16'h000C);
        smp(16'h0000, 16'h0000, 16'h4000, 16'h1000, 16'h0000);
        cmp(pol, 16'h2000);
        cmp(por, 16'h4000);
        wrr(4'h3, 16'h8080);
        smp(16'h0000, 16'h0000, 16'h4000, 16'h1000, 16'h0000);
        cmp(pol | por, 16'h0000);
        rdc(4'h7, 16'h8080);
        // zero-cross mode: no sign change until the timeout forces it, then a sign change applies at once
        wrr(4'h5, 16'h0081);
        wrr(4'h3, 16'h0808);
        smp(16'h0000, 16'h0000, 16'h1000, 16'h1000, 16'h0000);
        rdc(4'h6, 16'h0018);
        rdc(4'h7, 16'h8080);
        plays(378);
        rdc(4'h7, 16'h8080);
        plays(6);
        rdc(4'h7, 16'h0808);
        wrr(4'h3, 16'h1010);
        smp(16'h0000, 16'h0000, 16'hF000, 16'hF000, 16'h0000);
        cmp(pol, 16'hFC00);
        rdc(4'h7, 16'h1010);
        wrap_up();
    end
endmodule
